// ---- logic/rotate_datapath.v ----
`include "rotate_datapath_defs.vh"

module rotate_datapath (
  // clock and reset
  input  wire        mclk_i,
  input  wire        rst_n_i,
  // instruction from sequencer
  input  wire        instr_valid_i,
  input  wire [15:0] instr_i,
  // data inputs
  input  wire [15:0] port_data_i,
  input  wire [15:0] imm_data_i,
  // result bus
  output wire [15:0] result_bus_o,
  output wire        result_valid_o,
  output wire        illegal_o,
  // state
  output wire [15:0] work_o,
  output wire [7:0]  status_o
);

  // ----------------------------------------
  // operand, destination and function codes
  // ----------------------------------------
  localparam [4:0] SEL_SCR  = 5'h01;
  localparam [4:0] SEL_WORK = 5'h02;
  localparam [4:0] SEL_PORT = 5'h04;
  localparam [4:0] SEL_IMM  = 5'h08;
  localparam [4:0] SEL_ZERO = 5'h10;

  localparam [2:0] DST_WORK = 3'h1;
  localparam [2:0] DST_OUT  = 3'h2;
  localparam [2:0] DST_SCR  = 3'h4;

  localparam [3:0] FN_ROT = 4'h1;
  localparam [3:0] FN_MRG = 4'h2;
  localparam [3:0] FN_CMP = 4'h4;
  localparam [3:0] FN_PRI = 4'h8;

  reg  [15:0] scratch [0:31];
  reg  [15:0] work_q;
  reg  [15:0] work_d;
  reg  [7:0]  status_q;
  reg  [7:0]  status_d;

  wire        word_mode;
  wire [1:0]  quad;
  wire [3:0]  amount;
  wire [3:0]  opcode;
  wire [4:0]  addr;
  wire [15:0] scr_rd;

  reg         legal;
  reg  [3:0]  func;
  reg  [4:0]  u_sel;
  reg  [4:0]  r_sel;
  reg  [4:0]  s_sel;
  reg  [2:0]  dst;

  assign word_mode = instr_i[`IW_WIDTH_BIT];
  assign quad      = instr_i[`IW_QUAD_HI:`IW_QUAD_LO];
  assign amount    = instr_i[`IW_N_HI:`IW_N_LO];
  assign opcode    = instr_i[`IW_OP_HI:`IW_OP_LO];
  assign addr      = instr_i[`IW_ADDR_HI:`IW_ADDR_LO];
  assign scr_rd    = scratch[addr];

  // ----------------------------------------
  // operand mux
  // ----------------------------------------
  function [15:0] pick;
    input [4:0]  sel;
    input [15:0] scr_v;
    input [15:0] work_v;
    input [15:0] port_v;
    input [15:0] imm_v;
    begin
      case (sel)
        SEL_SCR:  pick = scr_v;
        SEL_WORK: pick = work_v;
        SEL_PORT: pick = port_v;
        SEL_IMM:  pick = imm_v;
        default:  pick = 16'h0000;
      endcase
    end
  endfunction

  // ----------------------------------------
  // instruction decode
  // ----------------------------------------
  always @* begin
    legal = 1'b0;
    func  = FN_ROT;
    u_sel = SEL_SCR;
    r_sel = SEL_SCR;
    s_sel = SEL_ZERO;
    dst   = DST_OUT;
    case (quad)
      `QUAD_00: begin
        case (opcode)
          `OP_ROT_TO_WORK: begin
            legal = 1'b1;
            dst   = DST_WORK;
          end
          `OP_ROT_TO_OUT: begin
            legal = 1'b1;
            dst   = DST_OUT;
          end
          `OP_ROT_IN_PLACE: begin
            legal = 1'b1;
            dst   = DST_SCR;
          end
          default: legal = 1'b0;
        endcase
      end
      `QUAD_01: begin
        legal = 1'b1;
        case (opcode)
          `OP_ROT_WORK_SCR: begin
            u_sel = SEL_WORK;
            dst   = DST_SCR;
          end
          `OP_ROT_PORT_SCR: begin
            u_sel = SEL_PORT;
            dst   = DST_SCR;
          end
          `OP_MRG_PWI: begin
            func  = FN_MRG;
            u_sel = SEL_PORT;
            r_sel = SEL_WORK;
            s_sel = SEL_IMM;
            dst   = DST_WORK;
          end
          `OP_MRG_PWS: begin
            func  = FN_MRG;
            u_sel = SEL_PORT;
            r_sel = SEL_WORK;
            s_sel = SEL_SCR;
            dst   = DST_WORK;
          end
          `OP_MRG_PSI: begin
            func  = FN_MRG;
            u_sel = SEL_PORT;
            r_sel = SEL_SCR;
            s_sel = SEL_IMM;
            dst   = DST_SCR;
          end
          `OP_MRG_PSW: begin
            func  = FN_MRG;
            u_sel = SEL_PORT;
            r_sel = SEL_SCR;
            s_sel = SEL_WORK;
            dst   = DST_SCR;
          end
          `OP_MRG_WSI: begin
            func  = FN_MRG;
            u_sel = SEL_WORK;
            r_sel = SEL_SCR;
            s_sel = SEL_IMM;
            dst   = DST_SCR;
          end
          `OP_MRG_SWI: begin
            func  = FN_MRG;
            u_sel = SEL_SCR;
            r_sel = SEL_WORK;
            s_sel = SEL_IMM;
            dst   = DST_WORK;
          end
          `OP_CMP_PWI: begin
            func  = FN_CMP;
            u_sel = SEL_PORT;
            r_sel = SEL_WORK;
            s_sel = SEL_IMM;
          end
          `OP_CMP_PSI: begin
            func  = FN_CMP;
            u_sel = SEL_PORT;
            r_sel = SEL_SCR;
            s_sel = SEL_IMM;
          end
          `OP_CMP_PSW: begin
            func  = FN_CMP;
            u_sel = SEL_PORT;
            r_sel = SEL_SCR;
            s_sel = SEL_WORK;
          end
          `OP_CMP_SWI: begin
            func  = FN_CMP;
            u_sel = SEL_SCR;
            r_sel = SEL_WORK;
            s_sel = SEL_IMM;
          end
          default: legal = 1'b0;
        endcase
      end
      `QUAD_10: begin
        // scratch register is the mask here
        func  = FN_PRI;
        s_sel = SEL_SCR;
        legal = 1'b1;
        case (amount)
          `PR_DST_WORK: dst = DST_WORK;
          `PR_DST_OUT:  dst = DST_OUT;
          `PR_DST_SCR:  dst = DST_SCR;
          default:      legal = 1'b0;
        endcase
        case (opcode)
          `PR_SRC_WORK: r_sel = SEL_WORK;
          `PR_SRC_PORT: r_sel = SEL_PORT;
          default:      legal = 1'b0;
        endcase
      end
      default: begin
        if (opcode == `OP_NON_REGISTER) begin
          legal = 1'b1;
          case (addr)
            `NR_PORT_TO_OUT: begin
              u_sel = SEL_PORT;
              dst   = DST_OUT;
            end
            `NR_PORT_TO_WORK: begin
              u_sel = SEL_PORT;
              dst   = DST_WORK;
            end
            `NR_WORK_TO_OUT: begin
              u_sel = SEL_WORK;
              dst   = DST_OUT;
            end
            `NR_WORK_IN_PLACE: begin
              u_sel = SEL_WORK;
              dst   = DST_WORK;
            end
            default: legal = 1'b0;
          endcase
        end else begin
          // operand and mask are assumed distinct here
          func  = FN_PRI;
          legal = 1'b1;
          case (amount)
            `PR_MSK_WORK: s_sel = SEL_WORK;
            `PR_MSK_ZERO: s_sel = SEL_ZERO;
            default:      legal = 1'b0;
          endcase
          case (opcode)
            `PR_NR_SRC_WORK: r_sel = SEL_WORK;
            `PR_NR_SRC_PORT: r_sel = SEL_PORT;
            default:         legal = 1'b0;
          endcase
          case (addr)
            `PR_NR_DST_OUT:  dst = DST_OUT;
            `PR_NR_DST_WORK: dst = DST_WORK;
            default:         legal = 1'b0;
          endcase
        end
      end
    endcase
  end

  // ----------------------------------------
  // datapath
  // ----------------------------------------
  wire [15:0] u_val;
  wire [15:0] r_val;
  wire [15:0] s_val;
  wire [15:0] rot_val;
  wire [15:0] mrg_val;
  wire [15:0] cmp_val;
  wire [15:0] pri_in;
  reg  [4:0]  pri_code;
  reg  [15:0] result;
  reg  [15:0] dst_old;
  wire [15:0] wr_data;
  wire        res_neg;
  wire        res_zero;
  integer     k;

  assign u_val = pick(u_sel, scr_rd, work_q, port_data_i, imm_data_i);
  assign r_val = pick(r_sel, scr_rd, work_q, port_data_i, imm_data_i);
  assign s_val = pick(s_sel, scr_rd, work_q, port_data_i, imm_data_i);

  barrel_rotator u_rot (
    .src_i       (u_val),
    .amount_i    (amount),
    .word_mode_i (word_mode),
    .rot_o       (rot_val)
  );

  assign mrg_val = (r_val & ~s_val) | (rot_val & s_val);
  assign cmp_val = (r_val & ~s_val) ^ (rot_val & ~s_val);
  assign pri_in  = r_val & ~s_val;

  always @* begin
    pri_code = 5'h00;
    for (k = 0; k < 16; k = k + 1) begin
      if (word_mode && pri_in[k]) begin
        pri_code = `PRI_WORD_BASE - k[4:0];
      end else if (!word_mode && k < 8 && pri_in[k]) begin
        pri_code = `PRI_BYTE_BASE - k[4:0];
      end
    end
  end

  always @* begin
    case (func)
      FN_ROT:  result = rot_val;
      FN_MRG:  result = word_mode ? mrg_val : {r_val[15:8], mrg_val[7:0]};
      FN_CMP:  result = word_mode ? cmp_val : {8'h00, cmp_val[7:0]};
      FN_PRI:  result = {11'h000, pri_code};
      default: result = 16'h0000;
    endcase
  end

  always @* begin
    case (dst)
      DST_WORK: dst_old = work_q;
      DST_SCR:  dst_old = scr_rd;
      default:  dst_old = 16'h0000;
    endcase
  end

  // byte mode leaves the destination's upper byte alone
  assign wr_data  = word_mode ? result : {dst_old[15:8], result[7:0]};
  assign res_neg  = word_mode ? result[15] : result[7];
  assign res_zero = word_mode ? (result == 16'h0000) : (result[7:0] == 8'h00);

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign result_bus_o   = result;
  assign result_valid_o = instr_valid_i & legal & (dst == DST_OUT);
  assign illegal_o      = instr_valid_i & ~legal;
  assign work_o         = work_q;
  assign status_o       = status_q;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always @* begin
    work_d   = work_q;
    status_d = status_q;
    if (instr_valid_i && legal) begin
      if (dst == DST_WORK) begin
        work_d = wr_data;
      end
      // link and user flags are untouched
      status_d[`ST_N]   = res_neg;
      status_d[`ST_Z]   = res_zero;
      status_d[`ST_OVR] = 1'b0;
      status_d[`ST_C]   = 1'b0;
    end
  end

  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      work_q   <= `WORK_RESET;
      status_q <= `ST_RESET;
    end else begin
      work_q   <= work_d;
      status_q <= status_d;
    end
  end

  always @(posedge mclk_i) begin
    if (rst_n_i && instr_valid_i && legal && dst == DST_SCR) begin
      scratch[addr] <= wr_data;
    end
  end

endmodule // rotate_datapath

// ---- logic/rotate_datapath_defs.vh ----
`ifndef ROTATE_DATAPATH_DEFS_VH
`define ROTATE_DATAPATH_DEFS_VH

// ----------------------------------------
// instruction word fields
// ----------------------------------------
`define IW_WIDTH_BIT   15
`define IW_QUAD_HI     14
`define IW_QUAD_LO     13
`define IW_N_HI        12
`define IW_N_LO        9
`define IW_OP_HI       8
`define IW_OP_LO       5
`define IW_ADDR_HI     4
`define IW_ADDR_LO     0

// ----------------------------------------
// quadrant codes
// ----------------------------------------
`define QUAD_00        2'h0
`define QUAD_01        2'h1
`define QUAD_10        2'h2
`define QUAD_11        2'h3

// ----------------------------------------
// rotate operation codes
// ----------------------------------------
`define OP_ROT_TO_WORK     4'hC
`define OP_ROT_TO_OUT      4'hE
`define OP_ROT_IN_PLACE    4'hF
`define OP_ROT_WORK_SCR    4'h0
`define OP_ROT_PORT_SCR    4'h1
`define OP_NON_REGISTER    4'hC
`define NR_PORT_TO_OUT     5'h18
`define NR_PORT_TO_WORK    5'h19
`define NR_WORK_TO_OUT     5'h1C
`define NR_WORK_IN_PLACE   5'h1D

// ----------------------------------------
// merge and compare operation codes
// ----------------------------------------
`define OP_MRG_PWI     4'h7
`define OP_MRG_PWS     4'h8
`define OP_MRG_PSI     4'h9
`define OP_MRG_PSW     4'hA
`define OP_MRG_WSI     4'hC
`define OP_MRG_SWI     4'hB
`define OP_CMP_PWI     4'h2
`define OP_CMP_PSI     4'h3
`define OP_CMP_PSW     4'h4
`define OP_CMP_SWI     4'h5

// ----------------------------------------
// prioritize codes
// ----------------------------------------
`define PR_DST_WORK    4'h8
`define PR_DST_OUT     4'hA
`define PR_DST_SCR     4'hB
`define PR_SRC_WORK    4'h7
`define PR_SRC_PORT    4'h9
`define PR_MSK_WORK    4'h8
`define PR_MSK_ZERO    4'hA
`define PR_NR_SRC_WORK 4'h4
`define PR_NR_SRC_PORT 4'h6
`define PR_NR_DST_OUT  5'h00
`define PR_NR_DST_WORK 5'h01

// ----------------------------------------
// status byte layout, reset values and prioritize code bases
// ----------------------------------------
`define ST_Z           0
`define ST_C           1
`define ST_N           2
`define ST_OVR         3
`define ST_RESET       8'h00
`define WORK_RESET     16'h0000
`define PRI_WORD_BASE  5'h10
`define PRI_BYTE_BASE  5'h08

`endif

// ---- logic/barrel_rotator.v ----
module barrel_rotator (
  // operand
  input  wire [15:0] src_i,
  input  wire [3:0]  amount_i,
  input  wire        word_mode_i,
  // result
  output wire [15:0] rot_o
);

  genvar i;
  generate
    for (i = 0; i < 16; i = i + 1) begin : g_bit
      localparam [3:0] POS = i;
      wire [3:0] idx_w;
      wire [2:0] idx_b;
      assign idx_w = POS - amount_i;
      assign idx_b = POS[2:0] - amount_i[2:0];
      if (i < 8) begin : g_low
        assign rot_o[i] = word_mode_i ? src_i[idx_w] : src_i[idx_b];
      end else begin : g_high
        assign rot_o[i] = word_mode_i ? src_i[idx_w] : src_i[i];
      end
    end
  endgenerate

endmodule // barrel_rotator

// ---- test/rotate_datapath_properties.sv ----
// --------
// port checks
// --------
module rotate_datapath_properties (
  // clock and reset
  input wire        mclk_i,
  input wire        rst_n_i,
  // instruction side
  input wire        instr_valid_i,
  input wire [15:0] instr_i,
  input wire [15:0] port_data_i,
  input wire [15:0] imm_data_i,
  // results
  input wire [15:0] result_bus_o,
  input wire        result_valid_o,
  input wire        illegal_o,
  input wire [15:0] work_o,
  input wire [7:0]  status_o
);
  timeunit 1ns;
  timeprecision 1ps;
  wire [31:0] dbl  = {work_o, work_o} << instr_i[12:9];
  wire [15:0] dbb  = {work_o[7:0], work_o[7:0]} << instr_i[11:9];
  wire        nr_y = instr_valid_i && instr_i[14:13] == 2'h3 && instr_i[8:0] == 9'h19C;
  wire        nr_w = instr_valid_i && instr_i[15:13] == 3'h7 && instr_i[8:0] == 9'h19D;
  wire        cmp  = instr_valid_i && instr_i[14:13] == 2'h1 && instr_i[8:5] >= 4'h2 && instr_i[8:5] <= 4'h5;
  wire        pry  = instr_valid_i && instr_i[14:13] == 2'h3 && instr_i[4:0] == 5'h00 &&
                     (instr_i[8:5] == 4'h4 || instr_i[8:5] == 4'h6) &&
                     (instr_i[12:9] == 4'h8 || instr_i[12:9] == 4'hA);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  a_illegal_no_write: assert property (illegal_o |=> $stable(work_o) && $stable(status_o))
    else $error("refused instruction changed state");
  a_idle_no_write: assert property (!instr_valid_i |=> $stable(work_o) && $stable(status_o))
    else $error("idle cycle changed state");
  a_valid_legal: assert property (result_valid_o |-> instr_valid_i && !illegal_o)
    else $error("bus valid without a legal instruction");
  a_flags_cleared: assert property (status_o[3] == 1'b0 && status_o[1] == 1'b0)
    else $error("overflow or carry set");
  a_upper_status: assert property (status_o[7:4] == 4'h0)
    else $error("link or user flags changed");
  a_rot_word_bus: assert property (nr_y && instr_i[15] |-> result_bus_o == dbl[31:16] && result_valid_o)
    else $error("word rotate on bus wrong");
  a_rot_byte_bus: assert property (nr_y && !instr_i[15] |-> result_bus_o == {work_o[15:8], dbb[15:8]})
    else $error("byte rotate on bus wrong");
  a_rot_in_place: assert property (nr_w |=> work_o == $past(dbl[31:16]) && status_o[2] == work_o[15])
    else $error("work rotate in place wrong");
  a_cmp_zero: assert property (cmp |=> status_o[0] == ($past(result_bus_o) == 16'h0000))
    else $error("compare zero flag wrong");
  a_pri_bus: assert property (pry |-> result_bus_o[15:5] == 11'h000 && result_valid_o)
    else $error("prioritize code too wide");
endmodule // rotate_datapath_properties

// ---- test/seq_model.sv ----
// --------
// sequencer model
// --------
module seq_model (
  // clock
  input  wire         mclk_i,
  // to datapath
  output logic        instr_valid_o,
  output logic [15:0] instr_o,
  output logic [15:0] port_data_o,
  output logic [15:0] imm_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    instr_valid_o = 1'b0;
    instr_o       = 16'h0000;
    port_data_o   = 16'h0000;
    imm_data_o    = 16'h0000;
  end
  // width bit passed as given
  task automatic issue(input logic [15:0] ins, input logic [15:0] d, input logic [15:0] im);
    logic [15:0] fix;
    fix = ins;
    if (ins[14:13] == 2'h3 && ins[8:5] == 4'h4 && ins[12:9] == 4'h8) fix[12:9] = 4'hA;
    instr_valid_o <= 1'b1;
    instr_o       <= fix;
    port_data_o   <= d;
    imm_data_o    <= im;
  endtask
  // idle toggles instruction and port lines, immediate holds
  task automatic idle();
    instr_valid_o <= 1'b0;
    instr_o       <= ~instr_o;
    port_data_o   <= ~port_data_o;
  endtask
endmodule // seq_model

// ---- test/tb.sv ----
`define CHK(nm, got, exp) begin n_compared++; if ((got) !== (exp)) begin mismatches++; \
  $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // --------
  // signals
  // --------
  logic        mclk_i  = 1'b0;
  logic        rst_n_i = 1'b0;
  wire         instr_valid_i;
  wire  [15:0] instr_i;
  wire  [15:0] port_data_i;
  wire  [15:0] imm_data_i;
  wire  [15:0] result_bus_o;
  wire         result_valid_o;
  wire         illegal_o;
  wire  [15:0] work_o;
  wire  [7:0]  status_o;
  logic [15:0] work_m;
  logic [7:0]  st_m;
  logic [15:0] scr_m [32];
  int          mismatches = 0;
  int          n_compared = 0;
  int          cyc        = 0;
  logic [63:0] cor [11] = '{64'hE199_AAAA_0000_AAAA, 64'hA8E0_3156_0F0F_A5A3, 64'hE199_15F0_0000_15F0,
    64'hA840_3156_00FF_0000, 64'hE998_137F_0000_37F1, 64'h6998_137F_0000_13F7, 64'hF4C0_8000_0000_0001,
    64'hF4C0_0001_0000_0010, 64'hF4C0_0000_0000_0000, 64'h74C0_FF00_0000_0000, 64'h74C0_0080_0000_0001};
  logic [31:0] tbl [31] = '{32'h0180_9E1F, 32'h01C0_9E1F, 32'h01E0_9E1F, 32'h2000_9E1F, 32'h2020_9E1F,
    32'h6198_9E00, 32'h6199_9E00, 32'h619C_9E00, 32'h619D_9E00, 32'h20E0_9E1F, 32'h2100_9E1F,
    32'h2120_9E1F, 32'h2140_9E1F, 32'h2160_9E1F, 32'h2180_9E1F, 32'h2040_9E1F, 32'h2060_9E1F,
    32'h2080_9E1F, 32'h20A0_9E1F, 32'h50E0_801F, 32'h5120_801F, 32'h54E0_801F, 32'h5520_801F,
    32'h56E0_801F, 32'h5720_801F, 32'h7080_8000, 32'h70C0_8000, 32'h7481_8000, 32'h74C1_8000,
    32'h70C1_8000, 32'h0000_801F};
  always #2.5 mclk_i = ~mclk_i;
  rotate_datapath i_rotate_datapath (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .port_data_i(port_data_i), .imm_data_i(imm_data_i), .result_bus_o(result_bus_o),
    .result_valid_o(result_valid_o), .illegal_o(illegal_o), .work_o(work_o), .status_o(status_o));
  seq_model i_seq_model (.mclk_i(mclk_i), .instr_valid_o(instr_valid_i), .instr_o(instr_i),
    .port_data_o(port_data_i), .imm_data_o(imm_data_i));
  // --------
  // reference model
  // --------
  function automatic logic [15:0] rot(input logic [15:0] v, input logic [3:0] n, input logic w);
    logic [31:0] t;
    logic [15:0] b;
    t = {v, v} << n;
    b = {v[7:0], v[7:0]} << n[2:0];
    return w ? t[31:16] : {v[15:8], b[15:8]};
  endfunction
  function automatic logic [15:0] pri(input logic [15:0] x, input logic w);
    logic [15:0] c;
    c = 16'h0000;
    for (int i = 0; i < 16; i++) if (x[i] && (w || i < 8)) c = 16'((w ? 16 : 8) - i);
    return c;
  endfunction
  function automatic logic [15:0] pick(input logic [2:0] sel, input logic [15:0] sr);
    case (sel)
      3'h0: return sr;
      3'h1: return work_m;
      3'h2: return port_data_i;
      3'h3: return imm_data_i;
      default: return 16'h0000;
    endcase
  endfunction
  function automatic logic [12:0] cf(input int k, input int d, input int u, input int r, input int s);
    return {2'(k), 2'(d), 3'(u), 3'(r), 3'(s)};
  endfunction
  task automatic model();
    logic [15:0] u, r, s, t, res, sr, old, nv, lo;
    logic [12:0] c;
    logic [3:0]  f;
    logic [4:0]  a;
    logic        w, ok;
    int          pd, nd;
    w  = instr_i[15];
    f  = instr_i[12:9];
    a  = instr_i[4:0];
    sr = scr_m[a];
    pd = f == 4'h8 ? 0 : f == 4'hA ? 1 : f == 4'hB ? 2 : 3;
    nd = (f != 4'h8 && f != 4'hA) ? 3 : a == 5'h00 ? 1 : a == 5'h01 ? 0 : 3;
    case ({instr_i[14:13], instr_i[8:5]})
      6'h0C: c = cf(0, 0, 0, 0, 4);
      6'h0E: c = cf(0, 1, 0, 0, 4);
      6'h0F: c = cf(0, 2, 0, 0, 4);
      6'h10: c = cf(0, 2, 1, 0, 4);
      6'h11: c = cf(0, 2, 2, 0, 4);
      6'h3C: c = cf(0, (a == 5'h18 || a == 5'h1C) ? 1 : (a == 5'h19 || a == 5'h1D) ? 0 : 3, a[2] ? 1 : 2, 0, 4);
      6'h17: c = cf(1, 0, 2, 1, 3);
      6'h18: c = cf(1, 0, 2, 1, 0);
      6'h19: c = cf(1, 2, 2, 0, 3);
      6'h1A: c = cf(1, 2, 2, 0, 1);
      6'h1C: c = cf(1, 2, 1, 0, 3);
      6'h1B: c = cf(1, 0, 0, 1, 3);
      6'h12: c = cf(2, 1, 2, 1, 3);
      6'h13: c = cf(2, 1, 2, 0, 3);
      6'h14: c = cf(2, 1, 2, 0, 1);
      6'h15: c = cf(2, 1, 0, 1, 3);
      6'h27: c = cf(3, pd, 0, 1, 0);
      6'h29: c = cf(3, pd, 0, 2, 0);
      6'h34: c = cf(3, nd, 0, 1, f == 4'h8 ? 1 : 4);
      6'h36: c = cf(3, nd, 0, 2, f == 4'h8 ? 1 : 4);
      default: c = cf(0, 3, 0, 0, 0);
    endcase
    u = pick(c[8:6], sr);
    r = pick(c[5:3], sr);
    s = pick(c[2:0], sr);
    t = rot(u, f, w);
    case (c[12:11])
      2'h0: res = t;
      2'h1: res = w ? (r & ~s) | (t & s) : {r[15:8], (r[7:0] & ~s[7:0]) | (t[7:0] & s[7:0])};
      2'h2: res = ((r & ~s) ^ (t & ~s)) & (w ? 16'hFFFF : 16'h00FF);
      default: res = pri(r & ~s, w);
    endcase
    lo = w ? res : {8'h00, res[7:0]};
    ok = instr_valid_i && c[10:9] != 2'h3;
    `CHK("illegal", illegal_o, instr_valid_i && !ok)
    `CHK("valid", result_valid_o, ok && c[10:9] == 2'h1)
    if (ok) begin
      `CHK("bus", result_bus_o, res)
      st_m = {st_m[7:4], 1'b0, w ? res[15] : res[7], 1'b0, lo == 16'h0000};
      old  = c[10:9] == 2'h0 ? work_m : sr;
      nv   = w ? res : {old[15:8], res[7:0]};
      if (c[10:9] == 2'h0) work_m = nv;
      if (c[10:9] == 2'h2) scr_m[a] = nv;
    end
  endtask
  // --------
  // sequence
  // --------
  task automatic step(input logic [15:0] ins, input logic [15:0] d, input logic [15:0] im, input logic v);
    @(posedge mclk_i);
    if (v) i_seq_model.issue(ins, d, im);
    else i_seq_model.idle();
    #1;
    `CHK("work", work_o, work_m)
    `CHK("status", status_o, st_m)
    model();
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      mismatches++;
      wrap_up();
    end
  end
  initial begin
    logic [31:0] e;
    work_m = 16'h0000;
    st_m   = 8'h00;
    void'($urandom(32'hA38D));
    repeat (4) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    for (int a = 0; a < 32; a++) step(16'hA020 | 16'(a), a == 0 ? 16'h0000 : 16'($urandom), 16'h0000, 1'b1);
    $display("test scratch_load done");
    foreach (cor[i]) begin
      step(cor[i][63:48], cor[i][47:32], cor[i][31:16], 1'b1);
      `CHK("corner", result_bus_o, cor[i][15:0])
    end
    $display("test corners done");
    repeat (400) begin
      e = tbl[$urandom % 31];
      step(e[31:16] | (16'($urandom) & e[15:0]), ($urandom % 4 == 0) ? 16'hFFFF : 16'($urandom),
           16'($urandom), 1'($urandom % 8 != 0));
    end
    step(16'h0000, 16'h0000, 16'h0000, 1'b0);
    $display("test random_sweep done");
    wrap_up();
  end
endmodule // tb
bind rotate_datapath rotate_datapath_properties i_rotate_datapath_properties (.mclk_i(mclk_i),
  .rst_n_i(rst_n_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i), .port_data_i(port_data_i),
  .imm_data_i(imm_data_i), .result_bus_o(result_bus_o), .result_valid_o(result_valid_o),
  .illegal_o(illegal_o), .work_o(work_o), .status_o(status_o));
